// ---- rtl/adc_calibration_control.sv ----
/*
 * Calibration control and conversion sequencing for a SAR converter,
 * with its 8-bit control register on the core register bus.
 * Assumes one core clock, synchronous inputs, byte-wide register access.
 */
// What this block does
// - Control register resets zero, byte access only
// - Bit 7 busy during conversion or calibration
// - Busy clears itself when work ends
// - Bits 5:4 pick 15, 1, 31, 63 readings
// - Bit 1: zero offset, one gain
// - Bit 0 launches calibration, self clears
// - Sample then convert, sequenced in hardware
// - SAR balances, result latched, 12 bits
`timescale 1ns/100ps
`default_nettype none
`include "adc_cal_consts.svh"
module adc_calibration_control
  import adc_cal_pkg::*;
#(
  parameter int WIDTH = 12,
  parameter logic [7:0] REG_ADDR = `CAL_CTRL_ADDR
) (
  input wire logic clock, // Core clock, 40 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [7:0] reg_addr, // Register address
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data
  input wire logic conv_start, // Single conversion request
  input wire logic cmp_high, // Comparator: trial above input
  output logic sample_en, // Sampling switches in track
  output logic [WIDTH-1:0] dac_code, // Trial code to the capacitor DAC
  output logic [WIDTH-1:0] conv_result, // Corrected conversion result
  output logic conv_done, // Result valid pulse
  output logic [WIDTH-1:0] offset_corr, // Stored offset correction
  output logic [WIDTH-1:0] gain_corr // Stored gain correction
);
  typedef struct packed {
    seq_state_t st;
    logic [3:0] tcnt;
    logic cal_run;
    logic [5:0] avg_left;
    logic [WIDTH+5:0] acc;
    logic [6:0] navg;
    logic [5:0] avg_cfg;
    logic enable_bit;
    logic kind;
    logic launch;
    logic [WIDTH-1:0] off;
    logic [WIDTH-1:0] gn;
    logic [WIDTH-1:0] res;
    logic dn;
  } ctl_regs_t;

  ctl_regs_t c_q;
  ctl_regs_t c_d;
  logic sar_start;
  logic sar_done;
  logic [WIDTH-1:0] sar_result;
  logic hit;

  // Averaging count decode, used by the register write and the calibration launch
  function automatic logic [5:0] avg_count(input logic [1:0] sel);
    unique case (sel)
      2'b00: avg_count = `CAL_AVG_15;
      2'b01: avg_count = `CAL_AVG_1;
      2'b10: avg_count = `CAL_AVG_31;
      2'b11: avg_count = `CAL_AVG_63;
    endcase
  endfunction

  function automatic logic [1:0] avg_code(input logic [5:0] n);
    unique case (n)
      `CAL_AVG_1: avg_code = 2'b01;
      `CAL_AVG_31: avg_code = 2'b10;
      `CAL_AVG_63: avg_code = 2'b11;
      default: avg_code = 2'b00;
    endcase
  endfunction

  // A partial match would alias neighbouring special registers
  // Whole-byte address match only
  assign hit = (reg_addr == REG_ADDR);

  // ****************************************
  // Sequencer and register next state
  // ****************************************
  always_comb begin
    c_d = c_q;
    c_d.dn = 1'b0;
    sar_start = 1'b0;
    // Writes ignored while busy so a running cycle keeps its setup
    if (reg_wr && hit && c_q.st == SQ_IDLE) begin
      c_d.avg_cfg = avg_count(reg_wdata[`CAL_BIT_AVG_HI:`CAL_BIT_AVG_LO]);
      c_d.enable_bit = reg_wdata[`CAL_BIT_ENABLE];
      c_d.kind = reg_wdata[`CAL_BIT_KIND];
      c_d.launch = reg_wdata[`CAL_BIT_LAUNCH];
      if (reg_wdata[`CAL_BIT_LAUNCH]) begin
        c_d.cal_run = 1'b1;
        c_d.avg_left = avg_count(reg_wdata[`CAL_BIT_AVG_HI:`CAL_BIT_AVG_LO]);
        c_d.navg = {1'b0, c_d.avg_left};
        c_d.acc = '0;
        c_d.st = SQ_SYNC;
        c_d.tcnt = `SYNC_CYCLES;
      end
    end
    unique case (c_q.st)
      SQ_IDLE: begin
        if (conv_start && !c_d.cal_run) begin
          c_d.st = SQ_SYNC;
          c_d.tcnt = `SYNC_CYCLES;
        end
      end
      SQ_SYNC: begin
        c_d.tcnt = c_q.tcnt - 4'h1;
        if (c_q.tcnt == 4'h1) begin
          c_d.st = SQ_SAMPLE;
          c_d.tcnt = `ACQ_CYCLES;
        end
      end
      SQ_SAMPLE: begin
        c_d.tcnt = c_q.tcnt - 4'h1;
        if (c_q.tcnt == 4'h1) begin
          c_d.st = SQ_APPROX;
          sar_start = 1'b1;
        end
      end
      SQ_APPROX: begin
        if (sar_done) begin
          if (c_q.cal_run) begin
            c_d.acc = c_q.acc + {6'h00, sar_result};
            c_d.avg_left = c_q.avg_left - 6'h01;
            if (c_q.avg_left == 6'h01) begin
              // One divide per calibration; a serial divider would save area
              // Store averaged correction
              if (c_q.kind) begin
                c_d.gn = WIDTH'(c_d.acc / c_q.navg);
              end else begin
                c_d.off = WIDTH'(c_d.acc / c_q.navg);
              end
              c_d.launch = 1'b0;
              c_d.cal_run = 1'b0;
              c_d.st = SQ_IDLE;
            end else begin
              c_d.st = SQ_SYNC;
              c_d.tcnt = `SYNC_CYCLES;
            end
          end else begin
            // Gain correction is held for software; only offset is removed
            // Apply stored offset
            c_d.res = WIDTH'(sar_result - c_q.off);
            c_d.dn = 1'b1;
            c_d.st = SQ_IDLE;
          end
        end
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      c_q <= '0;
      // Count 15 encodes as field 00, so the register still reads zero
      c_q.avg_cfg <= `CAL_AVG_15;
    end else begin
      c_q <= c_d;
    end
  end

  // ****************************************
  // Bit-trial engine
  // ****************************************
  sar_engine #(
    .WIDTH(WIDTH)
  ) u_sar (
    .clock(clock),
    .rst_n(rst_n),
    .start(sar_start),
    .cmp_high(cmp_high),
    .trial(dac_code),
    .done(sar_done),
    .result(sar_result)
  );

  // ****************************************
  // Register read port
  // ****************************************
  // Combinational so the core sees the byte in the cycle it asks
  // Read data; bits 6 and 3 read zero
  always_comb begin
    reg_rdata = 8'h00;
    if (reg_rd && hit) begin
      reg_rdata[`CAL_BIT_BUSY] = (c_q.st != SQ_IDLE);
      reg_rdata[`CAL_BIT_AVG_HI:`CAL_BIT_AVG_LO] = avg_code(c_q.avg_cfg);
      reg_rdata[`CAL_BIT_ENABLE] = c_q.enable_bit;
      reg_rdata[`CAL_BIT_KIND] = c_q.kind;
      reg_rdata[`CAL_BIT_LAUNCH] = c_q.launch;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Status decodes the state register only, so it never follows inputs
  assign sample_en = (c_q.st == SQ_SAMPLE);
  assign conv_result = c_q.res;
  assign conv_done = c_q.dn;
  assign offset_corr = c_q.off;
  assign gain_corr = c_q.gn;
endmodule
`default_nettype wire

// ---- rtl/adc_cal_consts.svh ----
/*
 * Offsets, field positions, reset values and timing counts for the
 * calibration control block. Assumes inclusion by bare name.
 */
`ifndef ADC_CAL_CONSTS_SVH
`define ADC_CAL_CONSTS_SVH

`define CAL_CTRL_ADDR 8'hF5
`define CAL_CTRL_RESET 8'h00
`define CAL_BIT_BUSY 7
`define CAL_BIT_AVG_HI 5
`define CAL_BIT_AVG_LO 4
`define CAL_BIT_ENABLE 2
`define CAL_BIT_KIND 1
`define CAL_BIT_LAUNCH 0
`define CAL_WRITE_MASK 8'h3F
`define CAL_AVG_15 6'h0F
`define CAL_AVG_1 6'h01
`define CAL_AVG_31 6'h1F
`define CAL_AVG_63 6'h3F
`define ACQ_CYCLES 4'h3
`define SYNC_CYCLES 4'h1

`endif

// ---- rtl/adc_cal_pkg.sv ----
/*
 * Types shared by the calibration control block.
 * Assumes the constants header is compiled alongside.
 */
package adc_cal_pkg;
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_SYNC = 2'b01,
    SQ_SAMPLE = 2'b10,
    SQ_APPROX = 2'b11
  } seq_state_t;

  typedef enum logic [1:0] {
    SAR_IDLE = 2'b00,
    SAR_STEP = 2'b01,
    SAR_DONE = 2'b10
  } sar_state_t;
endpackage

// ---- rtl/sar_engine.sv ----
/*
 * Successive-approximation stepping engine: one bit trial per cycle,
 * most significant bit first; final register content is latched.
 * Assumes the comparator answer is valid in the cycle the trial shows.
 */
`timescale 1ns/100ps
`default_nettype none
`include "adc_cal_consts.svh"
module sar_engine
  import adc_cal_pkg::*;
#(
  parameter int WIDTH = 12
) (
  input wire logic clock, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic start, // Begin approximation pulse
  input wire logic cmp_high, // Trial value above sampled input
  output logic [WIDTH-1:0] trial, // Trial code to the capacitor DAC
  output logic done, // Result ready pulse
  output logic [WIDTH-1:0] result // Latched result
);
  typedef struct packed {
    sar_state_t st;
    logic [WIDTH-1:0] successive_approx_register;
    logic [WIDTH-1:0] probe;
    logic [WIDTH-1:0] res;
    logic dn;
  } sar_regs_t;

  sar_regs_t s_q;
  sar_regs_t s_d;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.dn = 1'b0;
    unique case (s_q.st)
      SAR_IDLE: begin
        if (start) begin
          s_d.probe = {1'b1, {(WIDTH-1){1'b0}}};
          s_d.successive_approx_register = {1'b1, {(WIDTH-1){1'b0}}};
          s_d.st = SAR_STEP;
        end
      end
      SAR_STEP: begin
        if (cmp_high) begin
          s_d.successive_approx_register = s_q.successive_approx_register & ~s_q.probe;
        end
        s_d.probe = s_q.probe >> 1;
        s_d.successive_approx_register = s_d.successive_approx_register | (s_q.probe >> 1);
        if (s_q.probe[0]) begin
          s_d.st = SAR_DONE;
        end
      end
      SAR_DONE: begin
        s_d.res = s_q.successive_approx_register;
        s_d.dn = 1'b1;
        s_d.st = SAR_IDLE;
      end
      default: s_d.st = SAR_IDLE;
    endcase
  end

  // Register stage
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign trial = s_q.successive_approx_register;
  assign done = s_q.dn;
  assign result = s_q.res;
endmodule
`default_nettype wire

// ---- testbench/adc_cal_monitor.sv ----
/* Port assertions for the calibration control block.
   Assumes it is bound to every instance of that block. */
`timescale 1ns/100ps
`default_nettype none
`include "adc_cal_consts.svh"
module adc_cal_monitor #(parameter int WIDTH = 12) (
  input wire logic clock, // Core clock
  input wire logic rst_n, // Sync reset
  input wire logic [7:0] reg_addr, // Address
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic conv_start, // Request
  input wire logic sample_en, // Track phase
  input wire logic conv_done, // Result pulse
  input wire logic [WIDTH-1:0] conv_result // Result
);
  // ****************
  // Assertions
  // ****************
  logic hit;
  // Busy is visible only while the register is read
  assign hit = reg_rd && (reg_addr == `CAL_CTRL_ADDR);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_miss_zero: assert property (!hit |-> reg_rdata == 8'h00)
    else $error("stray read data");
  chk_rsvd_zero: assert property (hit |-> !reg_rdata[6] && !reg_rdata[3])
    else $error("reserved bit set");
  chk_done_time: assert property (hit && conv_start && !reg_rdata[7] |-> ##19 conv_done)
    else $error("done late");
  chk_busy_set: assert property (hit && conv_start && !reg_rdata[7] |=> (!hit || reg_rdata[7]) [*8])
    else $error("busy missing");
  chk_busy_track: assert property (sample_en && hit |-> reg_rdata[7])
    else $error("busy low in track");
  chk_busy_end: assert property (conv_done && hit && !reg_rdata[0] |-> !reg_rdata[7])
    else $error("busy stuck");
  chk_done_pulse: assert property (conv_done |=> !conv_done)
    else $error("done too long");
  chk_track_len: assert property ($rose(sample_en) |-> sample_en [*3] ##1 !sample_en)
    else $error("track length");
  chk_result_new: assert property ($changed(conv_result) |-> conv_done)
    else $error("result moved");
  cover property (conv_done);
  cover property (hit && reg_rdata[7]);
  cover property (hit && $fell(reg_rdata[0]));
endmodule
bind adc_calibration_control adc_cal_monitor #(.WIDTH(WIDTH)) mon (.clock(clock),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .conv_start(conv_start), .sample_en(sample_en), .conv_done(conv_done),
  .conv_result(conv_result));
`default_nettype wire

// ---- testbench/tb_adc_calibration_control.sv ----
/* Self-checking bench for the calibration control block.
   Assumes the block and its checker are compiled alongside. */
`timescale 1ns/100ps
`default_nettype none
module tb_adc_calibration_control;
  logic clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 1, conv_start = 0;
  logic [7:0] reg_addr = 8'hF5, reg_wdata = 8'h00, reg_rdata;
  logic [11:0] ain = 12'h000, dac_code, conv_result, offset_corr, gain_corr;
  logic sample_en, conv_done;
  wire logic cmp_high;
  int err_total = 0, checks = 0, cyc;
  int n[4] = '{15, 1, 31, 63};
  // Ideal comparator against a held input level
  assign cmp_high = (dac_code > ain);
  always #12.5 clock = ~clock;
  adc_calibration_control dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .conv_start(conv_start), .cmp_high(cmp_high), .sample_en(sample_en),
    .dac_code(dac_code), .conv_result(conv_result), .conv_done(conv_done),
    .offset_corr(offset_corr), .gain_corr(gain_corr));
  // ****************
  // Tasks
  // ****************
  task results;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Strobe lasts one cycle; address returns to the register
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr = 1; reg_addr = a; reg_wdata = d;
    @(negedge clock);
    reg_wr = 0; reg_addr = 8'hF5;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    reg_addr = a;
    #1 chk(12'(reg_rdata), 12'(exp));
    @(negedge clock);
    reg_addr = 8'hF5;
  endtask
  // Bounded wait for busy to drop
  task idle(input int lim);
    cyc = 0;
    while (reg_rdata[7] !== 1'b0) begin
      @(negedge clock);
      cyc++;
      if (cyc > lim) begin
        err_total++;
        $display("[FAIL] %0t busy stuck", $time);
        results();
      end
    end
  endtask
  // A second request at cycle 5 must be dropped
  task conv(input logic [11:0] v, input logic [11:0] exp);
    ain = v;
    @(negedge clock);
    conv_start = 1;
    cyc = 0;
    while (conv_done !== 1'b1 && cyc < 40) begin
      @(negedge clock);
      cyc++;
      conv_start = (cyc == 5);
      if (cyc == 1) chk(12'(reg_rdata[7]), 12'h001);
    end
    // Raised before the taking edge, so done shows on the nineteenth falling edge
    chk(12'(cyc), 12'h013);
    chk(conv_result, exp);
    if (cyc >= 40) results();
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (2) @(negedge clock);
    rst_n = 1;
    rd(8'hF5, 8'h00);
    rd(8'hF4, 8'h00);
    wr(8'hF5, 8'hB2);
    rd(8'hF5, 8'h32);
    reg_rd = 0;
    #1 chk(12'(reg_rdata), 12'h000);
    @(negedge clock);
    reg_rd = 1;
    wr(8'hF5, 8'h00);
    conv(12'h5A3, 12'h5A3);
    rd(8'hF5, 8'h00);
    // Every average count, offset kind
    for (int k = 0; k < 4; k++) begin
      ain = 12'(k + 3);
      wr(8'hF5, 8'(5 + k * 16));
      idle(1400);
      // Each reading takes the full 18-cycle conversion
      chk(12'(cyc), 12'(n[k] * 18));
      rd(8'hF5, 8'(4 + k * 16));
      chk(offset_corr, ain);
    end
    conv(12'h064, 12'h05E);
    ain = 12'h7C0;
    wr(8'hF5, 8'h17);
    wr(8'hF5, 8'h00);
    idle(100);
    rd(8'hF5, 8'h16);
    chk(gain_corr, 12'h7C0);
    chk(offset_corr, 12'h006);
    results();
  end
endmodule
`default_nettype wire
